//--- logic/cfp_pkg.sv
// package of offsets, field positions and reset values for the config fuse block
package cfp_pkg;
   // register byte offsets on the apb bus
   localparam logic [7:0] CFP_OFF_CPU = 8'h00;
   localparam logic [7:0] CFP_OFF_CODE_LO = 8'h04;
   localparam logic [7:0] CFP_OFF_CODE_HI = 8'h08;
   localparam logic [7:0] CFP_OFF_WR_LO = 8'h0c;
   localparam logic [7:0] CFP_OFF_WR_HI = 8'h10;
   localparam logic [7:0] CFP_OFF_CTRL = 8'h14;
   localparam logic [7:0] CFP_OFF_ACCESS = 8'h18;
   localparam logic [7:0] CFP_OFF_STATUS = 8'h1c;
   // field positions in the cpu option byte
   localparam int CFP_BIT_DEBUG = 7;
   localparam int CFP_BIT_EXT = 6;
   localparam int CFP_BIT_BOOT_SIZE = 3;
   localparam int CFP_BIT_LOW_VOLT = 2;
   localparam int CFP_BIT_STACK = 0;
   // field positions in the lock bytes
   localparam int CFP_BIT_BLOCK1 = 1;
   localparam int CFP_BIT_BLOCK0 = 0;
   localparam int CFP_BIT_EEPROM = 7;
   localparam int CFP_BIT_BOOT = 6;
   localparam int CFP_BIT_CONFIG = 5;
   // implemented bit masks
   localparam logic [7:0] CFP_MASK_CPU = 8'hcd;
   localparam logic [7:0] CFP_MASK_LO = 8'h03;
   localparam logic [7:0] CFP_MASK_CODE_HI = 8'hc0;
   localparam logic [7:0] CFP_MASK_WR_HI = 8'he0;
   // unprogrammed values
   localparam logic [7:0] CFP_RST_CPU = 8'h85;
   localparam logic [7:0] CFP_RST_LO = 8'h03;
   localparam logic [7:0] CFP_RST_CODE_HI = 8'hc0;
   localparam logic [7:0] CFP_RST_WR_HI = 8'he0;
   // boot block sizes in words
   localparam logic [11:0] CFP_BOOT_2KW = 12'h800;
   localparam logic [11:0] CFP_BOOT_1KW = 12'h400;
   localparam logic [11:0] CFP_BOOT_512W = 12'h200;
   // program memory block 0 ends (exclusive) above the boot block
   localparam logic [15:0] CFP_BLOCK0_END_BIG = 16'h2000;
   localparam logic [15:0] CFP_BLOCK0_END_SMALL = 16'h1000;
   // access kinds on the access check port
   localparam logic [1:0] CFP_KIND_PROG = 2'h0;
   localparam logic [1:0] CFP_KIND_EEPROM = 2'h1;
   localparam logic [1:0] CFP_KIND_CONFIG = 2'h2;
   // programmer state encoding
   typedef enum logic [1:0]
   {
      CFP_ST_RUN = 2'b00,
      CFP_ST_PROG = 2'b01,
      CFP_ST_LEAVE = 2'b11
   } cfp_mode_type;
endpackage

//--- logic/cfp_sync.sv
// two flip-flop synchroniser for an asynchronous level
`timescale 1ns/10ps
`default_nettype none
module cfp_sync
   import cfp_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic async_in,
   output logic sync_out
);
   // first stage, read only by the second
   logic meta_reg;
   // two stage capture
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         meta_reg <= 1'b0;
         sync_out <= 1'b0;
      end
      else
      begin
         meta_reg <= async_in;
         sync_out <= meta_reg;
      end
   end
endmodule
`default_nettype wire

//--- logic/cfp_lock_byte.sv
// one clearable-only lock byte with mask and unprogrammed value
`timescale 1ns/10ps
`default_nettype none
module cfp_lock_byte
   import cfp_pkg::*;
#(
   parameter logic [7:0] MASK = 8'h03,
   parameter logic [7:0] INIT = 8'h03
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic wr_en,
   input wire logic [7:0] wr_data,
   output logic [7:0] value
);
   // stored byte
   logic [7:0] byte_reg;
   // a write may only clear bits, never set them
   wire [7:0] byte_next = byte_reg & (wr_data | ~MASK) & MASK;
   // hold unprogrammed value until cleared
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         byte_reg <= INIT;
      else if (wr_en)
         byte_reg <= byte_next;
   end
   // unimplemented positions read zero
   assign value = byte_reg & MASK;
   // a set bit can only appear through reset
   a_no_set_back: assert property
      (@(posedge pclk) disable iff (!presetn)
      (byte_reg & ~$past(byte_reg)) == 8'h00)
      else $error("lock bit returned to one");
endmodule
`default_nettype wire

//--- logic/cfp_top.sv
// config fuse protection block with apb registers and access checking
//
// Contract
// - without debug variant, debug bit reads one
// - bit 6 enables extended instruction set
// - bit 3 selects boot block size per variant
// - low voltage programming only when bit 2 set
// - stack fault reset only when bit 0 set
// - unimplemented bits read zero
// - code lock low protects blocks 1 and 0
// - code lock high bit 7 protects eeprom
// - code lock high bit 6 protects boot
// - write lock low protects blocks 1 and 0
// - write lock high bit 7 protects eeprom
// - write lock high bit 6 protects boot
// - write lock high bit 5 protects config
// - config lock changes only in program mode
// - lock bits only clear, never set
// - unprogrammed values of all fields
//
// The register offsets and register access over APB were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module cfp_top
   import cfp_pkg::*;
#(
   parameter bit DEBUG_VARIANT = 1'b0,
   parameter bit LARGE_VARIANT = 1'b1
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic program_mode_pin,
   input wire logic stack_fault,
   input wire logic lv_entry_req,
   input wire logic [15:0] nvm_addr,
   input wire logic [1:0] nvm_kind,
   input wire logic [7:0] nvm_rd_raw,
   output logic nvm_wr_allow,
   output logic [7:0] nvm_rd_data,
   output logic debugger_enable,
   output logic extended_instruction_enable,
   output logic [11:0] boot_region_size,
   output logic lv_entry_grant,
   output logic stack_fault_reset
);
   // synchronised program mode level
   logic prog_sync;
   // programmer state
   cfp_mode_type mode_reg;
   cfp_mode_type mode_next;
   // cpu option byte, programmable bits
   logic [7:0] cpu_reg;
   // lock byte values
   logic [7:0] code_lo;
   logic [7:0] code_hi;
   logic [7:0] wr_lo;
   logic [7:0] wr_hi;
   // config write lock held apart because it needs program mode
   logic cfg_lock_reg;
   // registered outputs
   logic stack_reset_reg;
   logic lv_grant_reg;
   logic wr_allow_reg;
   logic [7:0] rd_data_reg;
   logic [31:0] prdata_reg;
   logic refused_reg;

   // program mode pin crosses into pclk
   cfp_sync u_prog_sync
   (
      .pclk(pclk),
      .presetn(presetn),
      .async_in(program_mode_pin),
      .sync_out(prog_sync)
   );

   // apb decode, one cycle access, answer on the access phase
   wire access = psel & penable;
   wire wr_strobe = access & pwrite;
   wire in_prog = (mode_reg == CFP_ST_PROG);
   wire hit_cpu = (paddr == CFP_OFF_CPU);
   wire hit_code_lo = (paddr == CFP_OFF_CODE_LO);
   wire hit_code_hi = (paddr == CFP_OFF_CODE_HI);
   wire hit_wr_lo = (paddr == CFP_OFF_WR_LO);
   wire hit_wr_hi = (paddr == CFP_OFF_WR_HI);
   wire hit_ctrl = (paddr == CFP_OFF_CTRL);
   wire hit_access = (paddr == CFP_OFF_ACCESS);
   wire hit_status = (paddr == CFP_OFF_STATUS);
   wire hit_any = hit_cpu | hit_code_lo | hit_code_hi | hit_wr_lo |
                  hit_wr_hi | hit_ctrl | hit_access | hit_status;
   // config bytes change only when unlocked and in program mode
   wire cfg_writable = in_prog & cfg_lock_reg;
   wire cfg_wr = wr_strobe & cfg_writable;
   wire cfg_hit = hit_cpu | hit_code_lo | hit_code_hi | hit_wr_lo | hit_wr_hi;
   // refused: unmapped, or config write outside allowed state
   wire bad_wr = wr_strobe & cfg_hit & ~cfg_writable;
   wire err_now = access & (~hit_any | bad_wr);

   // program mode tracker: run, prog, leave
   always_comb
   begin
      mode_next = mode_reg;
      case (mode_reg)
         CFP_ST_RUN:
            if (prog_sync)
               mode_next = CFP_ST_PROG;
         CFP_ST_PROG:
            if (!prog_sync)
               mode_next = CFP_ST_LEAVE;
         CFP_ST_LEAVE:
            mode_next = CFP_ST_RUN;
         default:
            mode_next = CFP_ST_RUN;
      endcase
   end

   // mode state register
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         mode_reg <= CFP_ST_RUN;
      else
         mode_reg <= mode_next;
   end

   // cpu option byte next value, debug bit taken from the write data like bits 6, 3, 2 and 0
   wire [7:0] cpu_next = (pwdata[7:0] & CFP_MASK_CPU) |
                         (CFP_RST_CPU & ~CFP_MASK_CPU);

   // cpu option byte store
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         cpu_reg <= CFP_RST_CPU;
      else if (cfg_wr & hit_cpu)
         cpu_reg <= cpu_next;
   end

   // config write lock: program mode only, clear only
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         cfg_lock_reg <= 1'b1;
      else if (cfg_wr & hit_wr_hi & ~pwdata[CFP_BIT_CONFIG])
         cfg_lock_reg <= 1'b0;
   end

   // clearable lock bytes
   cfp_lock_byte #(.MASK(CFP_MASK_LO), .INIT(CFP_RST_LO)) u_code_lo
   (
      .pclk(pclk),
      .presetn(presetn),
      .wr_en(cfg_wr & hit_code_lo),
      .wr_data(pwdata[7:0]),
      .value(code_lo)
   );
   cfp_lock_byte #(.MASK(CFP_MASK_CODE_HI), .INIT(CFP_RST_CODE_HI)) u_code_hi
   (
      .pclk(pclk),
      .presetn(presetn),
      .wr_en(cfg_wr & hit_code_hi),
      .wr_data(pwdata[7:0]),
      .value(code_hi)
   );
   cfp_lock_byte #(.MASK(CFP_MASK_LO), .INIT(CFP_RST_LO)) u_wr_lo
   (
      .pclk(pclk),
      .presetn(presetn),
      .wr_en(cfg_wr & hit_wr_lo),
      .wr_data(pwdata[7:0]),
      .value(wr_lo)
   );
   cfp_lock_byte #(.MASK(CFP_MASK_CODE_HI), .INIT(CFP_RST_CODE_HI)) u_wr_hi
   (
      .pclk(pclk),
      .presetn(presetn),
      .wr_en(cfg_wr & hit_wr_hi),
      .wr_data(pwdata[7:0]),
      .value(wr_hi)
   );

   // debug bit reads one on parts without the debug variant
   wire debug_bit = DEBUG_VARIANT ? cpu_reg[CFP_BIT_DEBUG] : 1'b1;
   wire [7:0] cpu_view = {debug_bit, cpu_reg[6:0] & CFP_MASK_CPU[6:0]};
   wire [7:0] wr_hi_view = (wr_hi & CFP_MASK_CODE_HI) |
                           {2'b00, cfg_lock_reg, 5'b00000};

   // option decode
   assign debugger_enable = ~debug_bit;
   assign extended_instruction_enable = cpu_reg[CFP_BIT_EXT];
   // boot block size depends on variant and bit 3
   wire [11:0] size_big = cpu_reg[CFP_BIT_BOOT_SIZE] ?
                          CFP_BOOT_2KW : CFP_BOOT_1KW;
   wire [11:0] size_small = cpu_reg[CFP_BIT_BOOT_SIZE] ?
                            CFP_BOOT_1KW : CFP_BOOT_512W;
   assign boot_region_size = LARGE_VARIANT ? size_big : size_small;

   // region decode of the checked address
   wire [15:0] boot_end = {4'h0, boot_region_size};
   wire [15:0] blk0_end = LARGE_VARIANT ? CFP_BLOCK0_END_BIG :
                          CFP_BLOCK0_END_SMALL;
   wire is_prog = (nvm_kind == CFP_KIND_PROG);
   wire is_eeprom = (nvm_kind == CFP_KIND_EEPROM);
   wire is_config = (nvm_kind == CFP_KIND_CONFIG);
   wire in_boot = is_prog & (nvm_addr < boot_end);
   wire in_blk0 = is_prog & ~in_boot & (nvm_addr < blk0_end);
   wire in_blk1 = is_prog & ~in_boot & ~in_blk0;
   // write locks, zero means protected
   wire wr_locked = (in_blk1 & ~wr_lo[CFP_BIT_BLOCK1]) |
                    (in_blk0 & ~wr_lo[CFP_BIT_BLOCK0]) |
                    (is_eeprom & ~wr_hi[CFP_BIT_EEPROM]) |
                    (in_boot & ~wr_hi[CFP_BIT_BOOT]) |
                    (is_config & ~cfg_lock_reg);
   // code locks, zero means protected
   wire rd_locked = (in_blk1 & ~code_lo[CFP_BIT_BLOCK1]) |
                    (in_blk0 & ~code_lo[CFP_BIT_BLOCK0]) |
                    (is_eeprom & ~code_hi[CFP_BIT_EEPROM]) |
                    (in_boot & ~code_hi[CFP_BIT_BOOT]);

   // registered gating of core requests and checked accesses
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         stack_reset_reg <= 1'b0;
         lv_grant_reg <= 1'b0;
         wr_allow_reg <= 1'b0;
         rd_data_reg <= 8'h00;
      end
      else
      begin
         stack_reset_reg <= stack_fault & cpu_reg[CFP_BIT_STACK];
         lv_grant_reg <= lv_entry_req & cpu_reg[CFP_BIT_LOW_VOLT];
         wr_allow_reg <= ~wr_locked;
         rd_data_reg <= rd_locked ? 8'h00 : nvm_rd_raw;
      end
   end
   assign stack_fault_reset = stack_reset_reg;
   assign lv_entry_grant = lv_grant_reg;
   assign nvm_wr_allow = wr_allow_reg;
   assign nvm_rd_data = rd_data_reg;

   // read mux
   wire [31:0] status_word = {28'h0000000, refused_reg, cfg_writable,
                              in_prog, prog_sync};
   wire [31:0] access_word = {30'h00000000, rd_locked, wr_locked};
   wire [31:0] rd_mux =
      hit_cpu ? {24'h000000, cpu_view} :
      hit_code_lo ? {24'h000000, code_lo} :
      hit_code_hi ? {24'h000000, code_hi} :
      hit_wr_lo ? {24'h000000, wr_lo} :
      hit_wr_hi ? {24'h000000, wr_hi_view} :
      hit_access ? access_word :
      hit_status ? status_word :
      32'h00000000;

   // read data and refused flag capture
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata_reg <= 32'h00000000;
         refused_reg <= 1'b0;
      end
      else
      begin
         if (psel & ~penable & ~pwrite)
            prdata_reg <= rd_mux;
         if (err_now)
            refused_reg <= 1'b1;
         else if (wr_strobe & hit_ctrl & pwdata[0])
            refused_reg <= 1'b0;
      end
   end
   assign prdata = prdata_reg;
   assign pready = 1'b1;
   assign pslverr = err_now;

   // outside program mode the config lock cannot drop
   a_cfg_lock_hold: assert property
      (@(posedge pclk) disable iff (!presetn)
      (!in_prog) |=> !$fell(cfg_lock_reg))
      else $error("config lock changed outside program mode");
   // no stack fault reset one cycle after a fault while bit 0 is clear
   a_stack_gate: assert property
      (@(posedge pclk) disable iff (!presetn)
      (stack_fault && !cpu_reg[CFP_BIT_STACK]) |=> !stack_fault_reset)
      else $error("stack fault reset while disabled");
   // the release edge still loads reset values, so it is left out
   a_stack_fire: assert property
      (@(posedge pclk) disable iff (!presetn)
      (presetn && stack_fault && cpu_reg[CFP_BIT_STACK]) |=> stack_fault_reset)
      else $error("stack fault reset missing");
   // low voltage entry needs its enable
   a_lowv_gate: assert property
      (@(posedge pclk) disable iff (!presetn)
      (lv_entry_req && !cpu_reg[CFP_BIT_LOW_VOLT]) |=> !lv_entry_grant)
      else $error("low voltage entry granted while disabled");
   a_lowv_fire: assert property
      (@(posedge pclk) disable iff (!presetn)
      (presetn && lv_entry_req && cpu_reg[CFP_BIT_LOW_VOLT])
      |=> lv_entry_grant)
      else $error("low voltage entry not granted");
   // locked writes refused next cycle
   a_wr_refuse: assert property
      (@(posedge pclk) disable iff (!presetn)
      wr_locked |=> !nvm_wr_allow)
      else $error("write allowed into locked region");
   // open regions stay writable
   a_wr_open: assert property
      (@(posedge pclk) disable iff (!presetn)
      (presetn && !wr_locked) |=> nvm_wr_allow)
      else $error("write refused in open region");
   // protected reads return zero
   a_rd_blank: assert property
      (@(posedge pclk) disable iff (!presetn)
      rd_locked |=> (nvm_rd_data == 8'h00))
      else $error("protected contents leaked");
   // open reads pass the raw byte through
   a_rd_pass: assert property
      (@(posedge pclk) disable iff (!presetn)
      (presetn && !rd_locked) |=> (nvm_rd_data == $past(nvm_rd_raw)))
      else $error("open read data wrong");
   // debug bit reads one without debug variant
   a_debug_one: assert property
      (@(posedge pclk) disable iff (!presetn)
      !DEBUG_VARIANT |-> (cpu_view[CFP_BIT_DEBUG] && !debugger_enable))
      else $error("debug bit not one");
   // unimplemented bits of the cpu byte stay zero
   a_cpu_unimpl: assert property
      (@(posedge pclk) disable iff (!presetn)
      (cpu_view & ~CFP_MASK_CPU) == 8'h00)
      else $error("unimplemented bit set");
   // refused config write leaves the cpu byte alone
   a_cpu_locked: assert property
      (@(posedge pclk) disable iff (!presetn)
      (bad_wr && hit_cpu) |=> $stable(cpu_reg))
      else $error("locked config write took effect");
   // once the config lock is down the cpu byte is frozen
   a_cfg_frozen: assert property
      (@(posedge pclk) disable iff (!presetn)
      (!cfg_lock_reg) |=> $stable(cpu_reg))
      else $error("cpu byte changed under config lock");
   // boot size is 2KW on the large variant with bit 3 set
   a_boot_size: assert property
      (@(posedge pclk) disable iff (!presetn)
      (LARGE_VARIANT && cpu_reg[CFP_BIT_BOOT_SIZE]) |->
      (boot_region_size == CFP_BOOT_2KW))
      else $error("boot size wrong");
endmodule
`default_nettype wire

//--- verif/cfp_prog_model.sv
// behavioural model of the external programmer beside the fuse block
`timescale 1ns/10ps
`default_nettype none
module cfp_prog_model
(
   input wire logic pclk,
   input wire logic want_prog,
   output logic program_mode_pin,
   output logic [7:0] nvm_rd_raw
);
   // start outside program mode with a non-trivial raw byte
   initial
   begin
      program_mode_pin = 1'b0;
      nvm_rd_raw = 8'h5a;
   end
   // pin follows the request; raw memory byte changes every cycle
   always @(posedge pclk)
   begin
      program_mode_pin <= want_prog;
      nvm_rd_raw <= nvm_rd_raw * 8'h05 + 8'h3b;
   end
endmodule
`default_nettype wire

//--- verif/tb.sv
// self-checking bench for the config fuse block with a register model
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, x) begin n_compared++; if ((g) !== (x)) begin errors++; \
   $display("ERROR at %0t got %h expected %h", $time, g, x); end end
module tb
   import cfp_pkg::*;
;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [7:0] paddr, nvm_rd_raw, nvm_rd_data;
   logic [31:0] pwdata, prdata;
   logic want_prog, program_mode_pin, stack_fault, lv_entry_req;
   logic [15:0] nvm_addr;
   logic [1:0] nvm_kind;
   logic nvm_wr_allow, debugger_enable, extended_instruction_enable;
   logic lv_entry_grant, stack_fault_reset;
   logic [11:0] boot_region_size;
   int errors = 0;
   int n_compared = 0;
   logic [31:0] m[5]; // model of the five fuse bytes
   bit inp; // model: device in program mode
   logic [31:0] s = 32'd76941; // xorshift state
   logic [15:0] tbl[4] = '{16'h03ff, 16'h0400, 16'h1fff, 16'h2000};
   cfp_top cfp_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .program_mode_pin(program_mode_pin), .stack_fault(stack_fault),
      .lv_entry_req(lv_entry_req), .nvm_addr(nvm_addr),
      .nvm_kind(nvm_kind), .nvm_rd_raw(nvm_rd_raw),
      .nvm_wr_allow(nvm_wr_allow), .nvm_rd_data(nvm_rd_data),
      .debugger_enable(debugger_enable),
      .extended_instruction_enable(extended_instruction_enable),
      .boot_region_size(boot_region_size),
      .lv_entry_grant(lv_entry_grant),
      .stack_fault_reset(stack_fault_reset));
   cfp_prog_model cfp_prog_model_inst (.pclk(pclk), .want_prog(want_prog),
      .program_mode_pin(program_mode_pin), .nvm_rd_raw(nvm_rd_raw));
   // 40 mhz clock
   initial
   begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end
   // pseudo random source
   function automatic logic [31:0] xs();
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      s = s ^ (s << 5);
      return s;
   endfunction
   // verdict and end of run
   task test_done;
      $display("compared %0d mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // unprogrammed contents of the model
   task mreset;
      m = '{32'h85, 32'h03, 32'hc0, 32'h03, 32'he0};
      inp = 1'b0;
   endtask
   // one apb transfer, waits for pready, then one idle cycle
   task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] r, output logic e);
      int i;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (i = 0; i < 20; i++)
      begin
         @(posedge pclk);
         if (pready === 1'b1)
            break;
      end
      if (i == 20)
      begin
         errors++;
         test_done;
      end
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   // write and update the model; refusal predicted from the model
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      logic x;
      int i;
      i = a >> 2;
      x = (a > 8'h1c) || (a[1:0] != 2'b00) ||
         (a <= 8'h10 && !(inp && m[4][5]));
      apb(1'b1, a, d, r, e);
      `CHK(e, x)
      if (!x && a <= 8'h10)
         m[i] = (i == 0) ? ((d & 32'h4d) | 32'h80) : (m[i] & d[7:0]);
   endtask
   // read and compare with the model
   task automatic rd(input logic [7:0] a);
      logic [31:0] r;
      logic e;
      apb(1'b0, a, 32'h0, r, e);
      `CHK(r, (a <= 8'h10) ? m[a >> 2] : 32'h0)
      `CHK(e, 1'b0)
   endtask
   // core option outputs against the cpu option byte
   task automatic outs();
      logic q, f;
      q = (xs() & 1) != 0;
      f = (xs() & 2) != 0;
      lv_entry_req <= q;
      stack_fault <= f;
      repeat (2) @(posedge pclk);
      `CHK(debugger_enable, 1'b0)
      `CHK(extended_instruction_enable, m[0][6])
      `CHK(boot_region_size, m[0][3] ? 12'h800 : 12'h400)
      `CHK(lv_entry_grant, q & m[0][2])
      `CHK(stack_fault_reset, f & m[0][0])
   endtask
   // memory access check at a random boundary address
   task automatic acc();
      logic [7:0] raw;
      logic [15:0] ad;
      logic [1:0] k;
      logic rl, wl, e;
      logic [31:0] r, ex;
      ad = tbl[xs() & 3];
      k = 2'(xs() % 3);
      nvm_addr <= ad;
      nvm_kind <= k;
      @(posedge pclk);
      raw = nvm_rd_raw;
      @(posedge pclk);
      if (k == 2'd2)
      begin
         rl = 1'b0;
         wl = !m[4][5];
      end
      else if (k == 2'd1)
      begin
         rl = !m[2][7];
         wl = !m[4][7];
      end
      else if (ad < (m[0][3] ? 16'h0800 : 16'h0400))
      begin
         rl = !m[2][6];
         wl = !m[4][6];
      end
      else if (ad < 16'h2000)
      begin
         rl = !m[1][0];
         wl = !m[3][0];
      end
      else
      begin
         rl = !m[1][1];
         wl = !m[3][1];
      end
      `CHK(nvm_wr_allow, !wl)
      `CHK(nvm_rd_data, rl ? 8'h00 : raw)
      ex = {30'h00000000, rl, wl};
      apb(1'b0, CFP_OFF_ACCESS, 32'h0, r, e);
      `CHK(r, ex)
   endtask
   // reset held for six cycles
   task hreset;
      presetn <= 1'b0;
      mreset;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
   endtask
   // hang guard
   initial
   begin
      repeat (50000) @(posedge pclk);
      errors++;
      test_done;
   end
   // main sequence
   initial
   begin
      logic [31:0] r, d;
      logic e;
      logic [7:0] a;
      int i;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {want_prog, stack_fault, lv_entry_req} = '0;
      {nvm_addr, nvm_kind} = '0;
      presetn = 1'b0;
      hreset;
      for (i = 0; i < 5; i++)
         rd(i * 4);
      outs();
      repeat (4) acc();
      $display("test unprogrammed done");
      wr(CFP_OFF_CODE_LO, 32'h0);
      wr(CFP_OFF_CPU, 32'hff);
      wr(8'h20, 32'h0);
      rd(CFP_OFF_CODE_LO);
      want_prog <= 1'b1;
      for (i = 0; i < 30; i++)
      begin
         apb(1'b0, CFP_OFF_STATUS, 32'h0, r, e);
         if (r[1] === 1'b1)
            break;
      end
      `CHK(r[1], 1'b1)
      inp = 1'b1;
      $display("test run mode done");
      wr(CFP_OFF_CPU, 32'hff);
      rd(CFP_OFF_CPU);
      outs();
      for (i = 0; i < 6; i++)
      begin
         wr(CFP_OFF_CPU, (i == 0) ? 32'h0 : xs());
         rd(CFP_OFF_CPU);
         outs();
         repeat (2) acc();
      end
      $display("test cpu options done");
      for (i = 0; i < 8; i++)
      begin
         a = 8'(((xs() & 3) + 1) * 4);
         d = xs() | xs();
         if (a == CFP_OFF_WR_HI)
            d = d | 32'h20;
         wr(a, d);
         wr(a, 32'hff);
         rd(a);
         repeat (3) acc();
      end
      $display("test lock bytes done");
      wr(CFP_OFF_WR_HI, 32'hdf);
      rd(CFP_OFF_WR_HI);
      wr(CFP_OFF_CPU, 32'h0);
      wr(CFP_OFF_CODE_LO, 32'h0);
      apb(1'b0, CFP_OFF_STATUS, 32'h0, r, e);
      `CHK(r[3:2], 2'b10)
      wr(CFP_OFF_CTRL, 32'h1);
      rd(CFP_OFF_CTRL);
      apb(1'b0, CFP_OFF_STATUS, 32'h0, r, e);
      `CHK(r[3], 1'b0)
      rd(CFP_OFF_CPU);
      repeat (4) acc();
      $display("test config lock done");
      want_prog <= 1'b0;
      repeat (4) @(posedge pclk);
      hreset;
      for (i = 0; i < 5; i++)
         rd(i * 4);
      outs();
      $display("test second reset done");
      test_done;
   end
endmodule
`default_nettype wire
